// file: logic/mfc_consts.svh
`ifndef MFC_CONSTS_SVH
`define MFC_CONSTS_SVH

// register indices; byte address is four times the index
`define MFC_IDX_PHY_DATA      6'h07
`define MFC_IDX_FLOW          6'h08
`define MFC_IDX_INT_STATUS    6'h10
`define MFC_IDX_INT_CLEAR     6'h11
`define MFC_IDX_INT_ENABLE    6'h12

// flow-control register fields
`define MFC_FLOW_PT_LSB       16
`define MFC_FLOW_PT_MSB       31
`define MFC_FLOW_PASS_BIT     2
`define MFC_FLOW_EN_BIT       1
`define MFC_FLOW_BUSY_BIT     0

// interrupt status bits
`define MFC_INT_PAUSE_SENT    0
`define MFC_INT_PAUSE_RCVD    1
`define MFC_INT_PAUSE_END     2
`define MFC_INT_WIDTH         3

// reset values
`define MFC_RST_PHY_DATA      16'h0000
`define MFC_RST_PAUSE_TIME    16'h0000
`define MFC_RST_INT           3'h0

// pause frame field values
`define MFC_PF_DEST_ADDR      48'h0180c2000001
`define MFC_PF_TYPE           16'h8808
`define MFC_PF_OPCODE         16'h0001

// timing: one slot is 512 bit times at 100 Mb/s
`define MFC_CLK_PERIOD_NS     100
`define MFC_SLOT_TIME_NS      5120
`define MFC_SLOT_CYCLES \
  ((`MFC_SLOT_TIME_NS + `MFC_CLK_PERIOD_NS - 1) / `MFC_CLK_PERIOD_NS)

`endif

// file: logic/mfc_flow_ctl.sv
`timescale 1ns/100ps
`include "mfc_consts.svh"

module mfc_flow_ctl #(
  parameter int SLOT_CYCLES = `MFC_SLOT_CYCLES
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // register port
  input  wire mfc_pkg::mfc_addr_t bus_addr,
  input  wire mfc_pkg::mfc_word_t bus_wdata,
  input  wire logic               bus_we,
  input  wire logic               bus_re,
  output mfc_pkg::mfc_word_t      bus_rdata,
  // interrupt
  output logic                    irq,
  // mac context
  input  wire logic               tx_enable,
  input  wire logic               full_duplex,
  // phy management data path
  input  wire logic               phy_rd_done,
  input  wire mfc_pkg::mfc_half_t phy_rd_data,
  output mfc_pkg::mfc_half_t      phy_wr_data,
  // requests from auto flow config
  input  wire logic               afc_pause_req,
  input  wire logic               afc_bp_req,
  // pause frame transmit
  output logic                    pf_tx_req,
  input  wire logic               pf_tx_start,
  input  wire logic               pf_tx_done,
  output mfc_pkg::mfc_half_t      pf_pause_time,
  output logic [47:0]             pf_dest_addr,
  output mfc_pkg::mfc_half_t      pf_type,
  output mfc_pkg::mfc_half_t      pf_opcode,
  // transmit throttle and back pressure
  output logic                    tx_pause,
  output logic                    bp_assert,
  // receive decode
  input  wire logic               rx_frame_end,
  input  wire logic               rx_is_pause,
  input  wire mfc_pkg::mfc_half_t rx_pause_time,
  input  wire logic               rx_filt_mode,
  input  wire logic               rx_filt_value,
  output logic                    rx_status_valid,
  output logic                    rx_status_filter
);
  import mfc_pkg::*;

  if (SLOT_CYCLES < 1) begin : g_slot_chk
    $error("SLOT_CYCLES must be at least 1");
  end

  // address decode
  logic hit_data;
  logic hit_flow;
  logic hit_ists;
  logic hit_iclr;
  logic hit_ien;

  assign hit_data = (bus_addr == {`MFC_IDX_PHY_DATA, 2'b00});
  assign hit_flow = (bus_addr == {`MFC_IDX_FLOW, 2'b00});
  assign hit_ists = (bus_addr == {`MFC_IDX_INT_STATUS, 2'b00});
  assign hit_iclr = (bus_addr == {`MFC_IDX_INT_CLEAR, 2'b00});
  assign hit_ien  = (bus_addr == {`MFC_IDX_INT_ENABLE, 2'b00});

  // configuration state
  mfc_half_t phy_data_reg;
  mfc_half_t phy_data_next;
  mfc_half_t pause_time_reg;
  mfc_half_t pause_time_next;
  logic      pass_reg;
  logic      pass_next;
  logic      fc_en_reg;
  logic      fc_en_next;

  always_comb begin
    phy_data_next   = phy_data_reg;
    pause_time_next = pause_time_reg;
    pass_next       = pass_reg;
    fc_en_next      = fc_en_reg;
    // hardware read data wins over a software write in the same cycle
    if (phy_rd_done) begin
      phy_data_next = phy_rd_data;
    end else if (bus_we && hit_data) begin
      phy_data_next = bus_wdata[15:0];
    end
    if (bus_we && hit_flow) begin
      pause_time_next = bus_wdata[`MFC_FLOW_PT_MSB:`MFC_FLOW_PT_LSB];
      pass_next       = bus_wdata[`MFC_FLOW_PASS_BIT];
      fc_en_next      = bus_wdata[`MFC_FLOW_EN_BIT];
      // bit 0 of the write is dropped here
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phy_data_reg   <= `MFC_RST_PHY_DATA;
      pause_time_reg <= `MFC_RST_PAUSE_TIME;
      pass_reg       <= 1'b0;
      fc_en_reg      <= 1'b0;
    end else begin
      phy_data_reg   <= phy_data_next;
      pause_time_reg <= pause_time_next;
      pass_reg       <= pass_next;
      fc_en_reg      <= fc_en_next;
    end
  end

  // pause frame transmit sequencing
  mfc_tx_state_e tx_state_reg;
  mfc_tx_state_e tx_state_next;
  mfc_half_t     pf_time_reg;
  mfc_half_t     pf_time_next;
  logic          bp_reg;
  logic          bp_next;
  logic          busy_reg;
  logic          busy_next;

  always_comb begin
    tx_state_next = tx_state_reg;
    pf_time_next  = pf_time_reg;
    case (tx_state_reg)
      MFC_TX_IDLE: begin
        if (afc_pause_req && full_duplex
            && tx_enable) begin
          tx_state_next = MFC_TX_REQ;
          pf_time_next  = pause_time_reg;
        end
      end
      MFC_TX_REQ: begin
        // a request not yet begun is withdrawn if the transmitter stops
        if (!tx_enable) begin
          tx_state_next = MFC_TX_IDLE;
        end else if (pf_tx_start) begin
          tx_state_next = MFC_TX_SEND;
        end
      end
      MFC_TX_SEND: begin
        if (pf_tx_done) begin
          tx_state_next = MFC_TX_IDLE;
        end
      end
      default: begin
        tx_state_next = MFC_TX_IDLE;
      end
    endcase
    bp_next = !full_duplex && fc_en_reg
              && tx_enable && afc_bp_req;
    if (full_duplex) begin
      busy_next = (tx_state_next == MFC_TX_SEND);
    end else begin
      busy_next = bp_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_state_reg <= MFC_TX_IDLE;
      pf_time_reg  <= `MFC_RST_PAUSE_TIME;
      bp_reg       <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      pf_time_reg  <= pf_time_next;
      bp_reg       <= bp_next;
      busy_reg     <= busy_next;
    end
  end

  // receive pause decode and status
  logic      rx_pause_ok;
  logic      rx_sv_reg;
  logic      rx_sv_next;
  logic      rx_sf_reg;
  logic      rx_sf_next;
  logic      timer_active;
  logic      timer_expired;

  // decode only happens with enable set and in full duplex
  assign rx_pause_ok = rx_frame_end && rx_is_pause && fc_en_reg
                       && full_duplex;

  always_comb begin
    rx_sv_next = rx_frame_end;
    rx_sf_next = rx_sf_reg;
    if (rx_frame_end) begin
      if (rx_filt_mode) begin
        rx_sf_next = rx_filt_value;
      end else begin
        rx_sf_next = pass_reg && rx_pause_ok;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_sv_reg <= 1'b0;
      rx_sf_reg <= 1'b0;
    end else begin
      rx_sv_reg <= rx_sv_next;
      rx_sf_reg <= rx_sf_next;
    end
  end

  mfc_pause_timer #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (rx_pause_ok),
    .quanta   (rx_pause_time),
    .active   (timer_active),
    .expired  (timer_expired)
  );

  // interrupts: status set beats clear in the same cycle
  logic [`MFC_INT_WIDTH-1:0] int_sts_reg;
  logic [`MFC_INT_WIDTH-1:0] int_sts_next;
  logic [`MFC_INT_WIDTH-1:0] int_en_reg;
  logic [`MFC_INT_WIDTH-1:0] int_en_next;
  logic [`MFC_INT_WIDTH-1:0] int_set;
  logic [`MFC_INT_WIDTH-1:0] int_clr;

  always_comb begin
    int_set = '0;
    int_set[`MFC_INT_PAUSE_SENT] = (tx_state_reg == MFC_TX_SEND) && pf_tx_done;
    int_set[`MFC_INT_PAUSE_RCVD] = rx_pause_ok;
    int_set[`MFC_INT_PAUSE_END]  = timer_expired;
    int_clr = (bus_we && hit_iclr) ? bus_wdata[`MFC_INT_WIDTH-1:0] : '0;
    int_sts_next = (int_sts_reg & ~int_clr) | int_set;
    int_en_next  = (bus_we && hit_ien) ? bus_wdata[`MFC_INT_WIDTH-1:0]
                                       : int_en_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_sts_reg <= `MFC_RST_INT;
      int_en_reg  <= `MFC_RST_INT;
    end else begin
      int_sts_reg <= int_sts_next;
      int_en_reg  <= int_en_next;
    end
  end

  // read data, one cycle after the strobe, zero otherwise
  mfc_word_t rdata_reg;
  mfc_word_t rdata_next;

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (!bus_re) begin
      rdata_next = 32'h0000_0000;
    end else if (hit_data) begin
      rdata_next = {16'h0000, phy_data_reg};
    end else if (hit_flow) begin
      rdata_next = {pause_time_reg, 13'h0000, pass_reg, fc_en_reg,
                    busy_reg};
    end else if (hit_ists) begin
      rdata_next = {29'h0000_0000, int_sts_reg};
    end else if (hit_ien) begin
      rdata_next = {29'h0000_0000, int_en_reg};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata        = rdata_reg;
  assign irq              = |(int_sts_reg & int_en_reg);
  assign phy_wr_data      = phy_data_reg;
  assign pf_tx_req        = (tx_state_reg == MFC_TX_REQ);
  assign pf_pause_time    = pf_time_reg;
  assign pf_dest_addr     = `MFC_PF_DEST_ADDR;
  assign pf_type          = `MFC_PF_TYPE;
  assign pf_opcode        = `MFC_PF_OPCODE;
  assign tx_pause         = timer_active;
  assign bp_assert        = bp_reg;
  assign rx_status_valid  = rx_sv_reg;
  assign rx_status_filter = rx_sf_reg;

  // assertions
  property p_busy_fd;
    @(posedge core_clk) disable iff (rst)
      (full_duplex && pf_tx_start && tx_state_reg == MFC_TX_REQ
       && tx_enable) |=> busy_reg;
  endproperty
  a_busy_fd: assert property (p_busy_fd)
    else $error("busy not set at pause frame start");

  property p_busy_clear;
    @(posedge core_clk) disable iff (rst)
      (full_duplex && tx_state_reg == MFC_TX_SEND && pf_tx_done
       ##1 full_duplex) |-> !busy_reg;
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("busy not cleared after frame sent");

  property p_busy_hd;
    @(posedge core_clk) disable iff (rst)
      !full_duplex |-> (busy_reg == bp_reg);
  endproperty
  a_busy_hd: assert property (p_busy_hd)
    else $error("half duplex busy differs from back pressure");

  property p_no_tx_when_off;
    @(posedge core_clk) disable iff (rst)
      (!tx_enable ##1 !tx_enable) |-> (!pf_tx_req && !bp_assert);
  endproperty
  a_no_tx_when_off: assert property (p_no_tx_when_off)
    else $error("pause or back pressure with transmitter off");

  property p_time_in_frame;
    @(posedge core_clk) disable iff (rst)
      (tx_state_reg == MFC_TX_IDLE && tx_state_next == MFC_TX_REQ)
      |=> (pf_pause_time == $past(pause_time_reg));
  endproperty
  a_time_in_frame: assert property (p_time_in_frame)
    else $error("pause time not taken from flow register");

  property p_filter_pass;
    @(posedge core_clk) disable iff (rst)
      (rx_frame_end && !rx_filt_mode) |=>
        (rx_status_filter == $past(pass_reg && rx_pause_ok));
  endproperty
  a_filter_pass: assert property (p_filter_pass)
    else $error("filter bit does not follow pass control");

  property p_filter_mode;
    @(posedge core_clk) disable iff (rst)
      (rx_frame_end && rx_filt_mode) |=>
        (rx_status_filter == $past(rx_filt_value));
  endproperty
  a_filter_mode: assert property (p_filter_mode)
    else $error("filter mode did not take precedence");

  property p_status_each;
    @(posedge core_clk) disable iff (rst)
      rx_frame_end |=> rx_status_valid;
  endproperty
  a_status_each: assert property (p_status_each)
    else $error("frame without receive status");

  property p_no_pause_off;
    @(posedge core_clk) disable iff (rst)
      (!fc_en_reg && !timer_active) |=> !tx_pause;
  endproperty
  a_no_pause_off: assert property (p_no_pause_off)
    else $error("pause started with flow control disabled");

  property p_pause_start;
    @(posedge core_clk) disable iff (rst)
      (rx_pause_ok && rx_pause_time != 16'h0000) |=> tx_pause [*2];
  endproperty
  a_pause_start: assert property (p_pause_start)
    else $error("received pause not obeyed");

  property p_busy_wr;
    @(posedge core_clk) disable iff (rst)
      (bus_we && hit_flow && bus_wdata[`MFC_FLOW_BUSY_BIT] && !afc_pause_req
       && !afc_bp_req && tx_state_reg == MFC_TX_IDLE) |=> !busy_reg;
  endproperty
  a_busy_wr: assert property (p_busy_wr)
    else $error("software write moved busy flag");

  c_pause_sent: cover property (@(posedge core_clk) disable iff (rst)
    pf_tx_start ##[1:50] pf_tx_done);
  c_pause_rcvd: cover property (@(posedge core_clk) disable iff (rst)
    rx_pause_ok ##1 tx_pause);
  c_backpress: cover property (@(posedge core_clk) disable iff (rst)
    bp_assert && busy_reg);
  c_irq: cover property (@(posedge core_clk) disable iff (rst)
    $rose(irq));

endmodule : mfc_flow_ctl

// file: logic/mfc_pause_timer.sv
`timescale 1ns/100ps
`include "mfc_consts.svh"

module mfc_pause_timer #(
  parameter int SLOT_CYCLES = `MFC_SLOT_CYCLES
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // control
  input  wire logic             load,
  input  wire mfc_pkg::mfc_half_t quanta,
  // status
  output logic                  active,
  output logic                  expired
);
  import mfc_pkg::*;

  localparam int SW = $clog2(SLOT_CYCLES + 1);

  if (SLOT_CYCLES < 1) begin : g_slot_chk
    $error("SLOT_CYCLES must be at least 1");
  end

  logic [15:0] quanta_reg;
  logic [15:0] quanta_next;
  logic [SW-1:0] slot_reg;
  logic [SW-1:0] slot_next;
  logic          exp_reg;
  logic          exp_next;

  always_comb begin
    quanta_next = quanta_reg;
    slot_next   = slot_reg;
    exp_next    = 1'b0;
    if (load) begin
      // a new pause replaces the running one; zero quanta resumes at once
      quanta_next = quanta;
      slot_next   = SW'(SLOT_CYCLES - 1);
      exp_next    = (quanta == 16'h0000) && (quanta_reg != 16'h0000);
    end else if (quanta_reg != 16'h0000) begin
      if (slot_reg == '0) begin
        quanta_next = quanta_reg - 16'h0001;
        slot_next   = SW'(SLOT_CYCLES - 1);
        exp_next    = (quanta_reg == 16'h0001);
      end else begin
        slot_next = slot_reg - SW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      quanta_reg <= 16'h0000;
      slot_reg   <= '0;
      exp_reg    <= 1'b0;
    end else begin
      quanta_reg <= quanta_next;
      slot_reg   <= slot_next;
      exp_reg    <= exp_next;
    end
  end

  assign active  = (quanta_reg != 16'h0000);
  assign expired = exp_reg;

endmodule : mfc_pause_timer

// file: logic/mfc_pkg.sv
package mfc_pkg;

  typedef logic [31:0] mfc_word_t;
  typedef logic [15:0] mfc_half_t;
  typedef logic [7:0]  mfc_addr_t;

  typedef enum logic [2:0] {
    MFC_TX_IDLE = 3'b001,
    MFC_TX_REQ  = 3'b010,
    MFC_TX_SEND = 3'b100
  } mfc_tx_state_e;

endpackage : mfc_pkg

// file: tb/mfc_link_model.sv
`timescale 1ns/100ps

module mfc_link_model (
  // clock
  input  wire logic        core_clk,
  // pause frame handshake
  input  wire logic        pf_tx_req,
  input  wire logic [15:0] pf_pause_time,
  input  wire logic        slow,
  output logic             pf_tx_start,
  output logic             pf_tx_done,
  output logic             in_frame,
  output logic [15:0]      sent_time,
  // received frame summary
  output logic             rx_frame_end,
  output logic             rx_is_pause,
  output logic [15:0]      rx_pause_time
);
  initial begin
    pf_tx_start   = 1'h0;
    pf_tx_done    = 1'h0;
    in_frame      = 1'h0;
    sent_time     = 16'h0;
    rx_frame_end  = 1'h0;
    rx_is_pause   = 1'h0;
    rx_pause_time = 16'h0;
  end

  // a slow link lets the request wait before the frame goes out
  always begin
    @(posedge core_clk);
    if (pf_tx_req) begin
      repeat (slow ? 5 : 0) @(posedge core_clk);
      pf_tx_start <= 1'h1;
      sent_time   <= pf_pause_time;
      in_frame    <= 1'h1;
      @(posedge core_clk);
      pf_tx_start <= 1'h0;
      repeat (6) @(posedge core_clk);
      pf_tx_done <= 1'h1;
      in_frame   <= 1'h0;
      @(posedge core_clk);
      pf_tx_done <= 1'h0;
    end
  end

  // lines between frames carry junk, not the last value
  task automatic send_rx(input logic pause, input logic [15:0] quanta);
    @(posedge core_clk);
    rx_frame_end  <= 1'h1;
    rx_is_pause   <= pause;
    rx_pause_time <= quanta;
    @(posedge core_clk);
    rx_frame_end  <= 1'h0;
    rx_is_pause   <= ~pause;
    rx_pause_time <= ~quanta;
  endtask : send_rx
endmodule : mfc_link_model

// file: tb/testbench.sv
`timescale 1ns/100ps

module testbench;
  import mfc_pkg::*;
  localparam int SLOT = 2;
  localparam mfc_addr_t FLOW = 8'h20;
  logic      core_clk = 1'h0;
  logic      rst = 1'h1;
  mfc_addr_t bus_addr = 8'h0;
  mfc_word_t bus_wdata = 32'h0;
  mfc_word_t bus_rdata;
  logic      bus_we = 1'h0, bus_re = 1'h0, tx_enable = 1'h0;
  logic      full_duplex = 1'h0, phy_rd_done = 1'h0, slow = 1'h0;
  logic      afc_pause_req = 1'h0, afc_bp_req = 1'h0;
  logic      rx_filt_mode = 1'h0, rx_filt_value = 1'h0;
  mfc_half_t phy_rd_data = 16'h0, phy_wr_data, pf_pause_time;
  mfc_half_t pf_type, pf_opcode, rx_pause_time, sent_time;
  logic [47:0] pf_dest_addr;
  logic      irq, pf_tx_req, pf_tx_start, pf_tx_done, tx_pause, bp_assert;
  logic      rx_frame_end, rx_is_pause, rx_status_valid, rx_status_filter;
  logic      in_frame;
  int        err_count = 0, samples_checked = 0, n;

  always #50 core_clk = ~core_clk;

  mfc_flow_ctl #(.SLOT_CYCLES(SLOT)) dut (
    .core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re),
    .bus_rdata(bus_rdata), .irq(irq), .tx_enable(tx_enable),
    .full_duplex(full_duplex), .phy_rd_done(phy_rd_done),
    .phy_rd_data(phy_rd_data), .phy_wr_data(phy_wr_data),
    .afc_pause_req(afc_pause_req), .afc_bp_req(afc_bp_req),
    .pf_tx_req(pf_tx_req), .pf_tx_start(pf_tx_start),
    .pf_tx_done(pf_tx_done), .pf_pause_time(pf_pause_time),
    .pf_dest_addr(pf_dest_addr), .pf_type(pf_type),
    .pf_opcode(pf_opcode), .tx_pause(tx_pause), .bp_assert(bp_assert),
    .rx_frame_end(rx_frame_end), .rx_is_pause(rx_is_pause),
    .rx_pause_time(rx_pause_time), .rx_filt_mode(rx_filt_mode),
    .rx_filt_value(rx_filt_value), .rx_status_valid(rx_status_valid),
    .rx_status_filter(rx_status_filter));

  mfc_link_model link (
    .core_clk(core_clk), .pf_tx_req(pf_tx_req),
    .pf_pause_time(pf_pause_time), .slow(slow),
    .pf_tx_start(pf_tx_start), .pf_tx_done(pf_tx_done),
    .in_frame(in_frame), .sent_time(sent_time),
    .rx_frame_end(rx_frame_end), .rx_is_pause(rx_is_pause),
    .rx_pause_time(rx_pause_time));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input mfc_addr_t a, input mfc_word_t d);
    @(posedge core_clk);
    bus_we    <= 1'h1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_we <= 1'h0;
  endtask : wr

  task automatic rd_raw(input mfc_addr_t a, output mfc_word_t d);
    @(posedge core_clk);
    bus_re   <= 1'h1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_re <= 1'h0;
    @(negedge core_clk);
    d = bus_rdata;
  endtask : rd_raw

  task automatic rd_chk(input mfc_addr_t a, input mfc_word_t exp);
    mfc_word_t d;
    rd_raw(a, d);
    check(d, exp);
  endtask : rd_chk

  // polling keeps software off the register while hardware owns it
  task automatic poll_busy(input logic exp);
    mfc_word_t d;
    for (int i = 0; i < 40; i++) begin
      rd_raw(FLOW, d);
      if (d[0] === exp) return;
    end
    err_count++;
    stop_test();
  endtask : poll_busy

  task automatic pulse_pause();
    @(posedge core_clk);
    afc_pause_req <= 1'h1;
    @(posedge core_clk);
    afc_pause_req <= 1'h0;
  endtask : pulse_pause

  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    rd_chk(8'h1c, 32'h0);
    rd_chk(FLOW, 32'h0);
    rd_chk(8'h30, 32'h0);
    rd_chk(8'h40, 32'h0);
    rd_chk(8'h48, 32'h0);
    wr(8'h1c, 32'hdeadbeef);
    rd_chk(8'h1c, 32'h0000beef);
    check(phy_wr_data, 16'hbeef);
    @(posedge core_clk);
    phy_rd_done <= 1'h1;
    phy_rd_data <= 16'h1234;
    @(posedge core_clk);
    phy_rd_done <= 1'h0;
    phy_rd_data <= 16'hedcb;
    rd_chk(8'h1c, 32'h00001234);
    $display("test phy data done");
    // pause time set before any pause is asked for; busy bit 1 on purpose
    wr(FLOW, 32'h00030007);
    rd_chk(FLOW, 32'h00030006);
    wr(8'h48, 32'h7);
    @(posedge core_clk);
    tx_enable   <= 1'h1;
    full_duplex <= 1'h1;
    for (int s = 0; s < 2; s++) begin
      @(posedge core_clk);
      slow <= s[0];
      pulse_pause();
      for (n = 0; n < 20 && in_frame !== 1'h1; n++) @(negedge core_clk);
      check(n < 20, 1'h1);
      if (n >= 20) stop_test();
      rd_chk(FLOW, 32'h00030007);
      check(pf_pause_time, 16'h0003);
      check(pf_dest_addr, 48'h0180c2000001);
      check({pf_type, pf_opcode}, 32'h88080001);
      poll_busy(1'h0);
      check(sent_time, 16'h0003);
      rd_chk(8'h40, 32'h1);
      check(irq, 1'h1);
      wr(8'h44, 32'h1);
      @(negedge core_clk);
      check(irq, 1'h0);
    end
    $display("test pause send done");
    @(posedge core_clk);
    tx_enable <= 1'h0;
    pulse_pause();
    full_duplex <= 1'h0;
    afc_bp_req  <= 1'h1;
    repeat (3) @(negedge core_clk);
    check({pf_tx_req, bp_assert}, 2'h0);
    @(posedge core_clk);
    tx_enable <= 1'h1;
    repeat (2) @(negedge core_clk);
    check(bp_assert, 1'h1);
    rd_chk(FLOW, 32'h00030007);
    @(posedge core_clk);
    afc_bp_req <= 1'h0;
    poll_busy(1'h0);
    wr(FLOW, 32'h00030004);
    afc_bp_req <= 1'h1;
    repeat (3) @(negedge core_clk);
    check(bp_assert, 1'h0);
    @(posedge core_clk);
    afc_bp_req <= 1'h0;
    $display("test back pressure done");
    full_duplex <= 1'h1;
    wr(FLOW, 32'h00030006);
    wr(8'h48, 32'h0);
    link.send_rx(1'h1, 16'h2);
    @(negedge core_clk);
    check({rx_status_valid, rx_status_filter}, 2'h3);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      if (tx_pause === 1'h1) n++;
      @(negedge core_clk);
    end
    check(n, 2 * SLOT);
    rd_chk(8'h40, 32'h6);
    check(irq, 1'h0);
    wr(8'h48, 32'h2);
    @(negedge core_clk);
    check(irq, 1'h1);
    wr(8'h44, 32'h6);
    @(negedge core_clk);
    check(irq, 1'h0);
    @(posedge core_clk);
    rx_filt_mode <= 1'h1;
    link.send_rx(1'h1, 16'h0);
    @(negedge core_clk);
    check(rx_status_filter, 1'h0);
    @(posedge core_clk);
    rx_filt_value <= 1'h1;
    link.send_rx(1'h0, 16'h0);
    @(negedge core_clk);
    check({rx_status_valid, rx_status_filter}, 2'h3);
    @(posedge core_clk);
    rx_filt_mode <= 1'h0;
    wr(FLOW, 32'h00030002);
    link.send_rx(1'h1, 16'h1);
    @(negedge core_clk);
    check({rx_status_filter, tx_pause}, 2'h1);
    repeat (4) @(negedge core_clk);
    wr(FLOW, 32'h00030004);
    link.send_rx(1'h1, 16'h3);
    @(negedge core_clk);
    check({rx_status_valid, rx_status_filter, tx_pause}, 3'h4);
    $display("test receive done");
    stop_test();
  end
endmodule : testbench
